// ==== core/srr_exec.sv ====
// Execution unit for float push, conditional returns and round
//
// Behaviour
// - Float push stores upper 32 register bits
// - Push increments stack pointer, then stores
// - Float push drops lowest eight mantissa bits
// - Push source read as floating-point value
// - Taken interrupt return loads PC, sets enable
// - Global enable unmasks individually enabled interrupts
// - Taken subroutine return loads PC, decrements pointer
// - Returns accept twenty condition codes
// - Tested flags come from register-targeting instructions
// - Push and returns ignore overflow mode
// - Round to nearest single precision value
// - Exact halfway rounds to more positive
// - Two-bit field selects round source mode
// - Round updates flags only for R0-R7
// - Round sets latched underflow, else unchanged
// - Round sets latched overflow, else unchanged
// - Underflow flag on underflow or zero source
// - Negative flag follows result sign
// - Overflow flag tracks overflow in either mode
`include "srr_defs.svh"

module srr_exec (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rstn,
  input  wire logic             i_req_valid,
  input  srr_pkg::srr_req_t     i_req,
  input  wire logic [31:0]      i_mem_rdata,
  input  wire logic [7:0]       i_irq_en,
  input  wire logic [7:0]       i_irq_pend,
  output logic                  o_busy,
  output logic                  o_done,
  output srr_pkg::srr_mem_t     o_mem,
  output srr_pkg::srr_wb_t      o_wb,
  output logic [23:0]           o_pc,
  output logic [23:0]           o_stack_pointer,
  output logic [31:0]           o_status_word,
  output logic [7:0]            o_irq_take
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////////////////

  // All state of the unit in one record
  typedef struct packed {
    srr_pkg::srr_state_t                   state;   // Sequencer
    logic [`SRR_NUM_REGS-1:0][39:0]        regs;    // Extended registers
    logic [23:0]                           pc;      // Program counter
    logic [23:0]                           sp;      // Stack pointer
    logic [31:0]                           st;      // Status word
    srr_pkg::srr_req_t                     req;     // Request in flight
    logic [31:0]                           data;    // Popped word
    srr_pkg::srr_mem_t                     mem;     // Memory request
    srr_pkg::srr_wb_t                      wb;      // Write-back report
    logic                                  busy;    // Multi-cycle op
    logic                                  done;    // Completion pulse
    logic [7:0]                            irq;     // Gated interrupts
  } srr_core_t;

  srr_core_t   q;          // Registered state
  srr_core_t   d;          // Next state
  logic        taken;      // Request accepted this cycle
  logic        cond_ok;    // Condition of incoming request
  logic        do_rnd;     // Round result commits this cycle
  logic [4:0]  rnd_dst;    // Round destination
  logic [39:0] rnd_src;    // Round operand, extended format
  logic [39:0] simm;       // Short immediate widened
  logic [42:0] rnd_res;    // {ovf, unf, zero, value}
  logic [31:0] push_word;  // Word a float push would store

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////////////////

  // Condition test over the status word; unlisted codes never pass
  function automatic logic srr_cond(input logic [4:0] c, input logic [31:0] s);
    logic t;
    t = 1'b0;
    case (c)
      `SRR_CC_U:    t = 1'b1;
      `SRR_CC_LO:   t = s[`SRR_C_BIT];
      `SRR_CC_LS:   t = s[`SRR_C_BIT] | s[`SRR_Z_BIT];
      `SRR_CC_HI:   t = !s[`SRR_C_BIT] & !s[`SRR_Z_BIT];
      `SRR_CC_HS:   t = !s[`SRR_C_BIT];
      `SRR_CC_EQ:   t = s[`SRR_Z_BIT];
      `SRR_CC_NE:   t = !s[`SRR_Z_BIT];
      `SRR_CC_LT:   t = s[`SRR_N_BIT];
      `SRR_CC_LE:   t = s[`SRR_N_BIT] | s[`SRR_Z_BIT];
      `SRR_CC_GT:   t = !s[`SRR_N_BIT] & !s[`SRR_Z_BIT];
      `SRR_CC_GE:   t = !s[`SRR_N_BIT];
      `SRR_CC_NV:   t = !s[`SRR_V_BIT];
      `SRR_CC_V:    t = s[`SRR_V_BIT];
      `SRR_CC_NUF:  t = !s[`SRR_UF_BIT];
      `SRR_CC_UF:   t = s[`SRR_UF_BIT];
      `SRR_CC_NLV:  t = !s[`SRR_LV_BIT];
      `SRR_CC_LV:   t = s[`SRR_LV_BIT];
      `SRR_CC_NLUF: t = !s[`SRR_LUF_BIT];
      `SRR_CC_LUF:  t = s[`SRR_LUF_BIT];
      `SRR_CC_ZUF:  t = s[`SRR_Z_BIT] | s[`SRR_UF_BIT];
      default:      t = 1'b0;
    endcase
    return t;
  endfunction

  // Round to single precision: add half an LSB at bit 7, then truncate.
  // Adding before truncating sends exact ties toward plus infinity.
  function automatic logic [42:0] srr_round(input logic [39:0] x, input logic sat);
    logic [7:0]  e;
    logic [32:0] s;
    logic [39:0] r;
    logic        ov;
    logic        un;
    logic        z;
    e  = x[39:32];
    s  = {x[31], x[31:0]} + `SRR_RND_HALF;
    r  = {e, s[31:0] & `SRR_LOW_MASK};
    ov = 1'b0;
    un = 1'b0;
    z  = 1'b0;
    if (e == `SRR_EXP_ZERO) begin
      // Any mantissa under the zero exponent is zero; a non-zero one
      // is reported as underflow
      z = (x[31:0] == '0);
      un = !z;
      r = {`SRR_EXP_ZERO, 32'h0000_0000};
    end else if (s[32] != s[31]) begin
      // Positive mantissa carried out: value is two to the next power
      if (e == `SRR_EXP_MAX) begin
        ov = 1'b1;
        // Saturate when the mode asks for it, else the exponent wraps
        r = sat ? {`SRR_EXP_MAX, `SRR_SAT_MANT} : {`SRR_EXP_ZERO, 32'h0000_0000};
      end else begin
        r = {e + `SRR_EXP_ONE, 32'h0000_0000};
      end
    end
    return {ov, un, z, r};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operand selection
  ////////////////////////////////////////////////////////////////////////////

  // Short immediate: 4-bit exponent, 12-bit signed mantissa
  always_comb begin
    simm[39:32] = (i_req.imm[15:12] == `SRR_SIMM_ZERO) ? `SRR_EXP_ZERO :
                  {{4{i_req.imm[15]}}, i_req.imm[15:12]};
    simm[31:0]  = {i_req.imm[11:0], {20{1'b0}}};
  end

  // Round operand comes from a register, the immediate or memory
  always_comb begin
    rnd_src = q.regs[i_req.src];
    rnd_dst = i_req.dst;
    do_rnd  = 1'b0;
    if (q.state == srr_pkg::SRR_WT) begin
      rnd_src = {i_mem_rdata, 8'h00};
      rnd_dst = q.req.dst;
      do_rnd  = (q.req.op == srr_pkg::SRR_OP_RND);
    end else if (taken && i_req.op == srr_pkg::SRR_OP_RND) begin
      if (i_req.amode == `SRR_AM_IMM) begin
        rnd_src = simm;
      end
      do_rnd = (i_req.amode == `SRR_AM_REG) || (i_req.amode == `SRR_AM_IMM);
    end
  end

  // Ready whenever no multi-cycle operation is in flight
  assign taken     = i_req_valid && !q.busy;
  assign cond_ok   = srr_cond(i_req.cond, q.st);
  assign rnd_res   = srr_round(rnd_src, q.st[`SRR_OVM_BIT]);
  assign push_word = q.regs[i_req.src][39:8];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  ////////////////////////////////////////////////////////////////////////////

  // Sequencer and datapath
  always_comb begin
    d          = q;
    d.done     = 1'b0;
    d.wb.valid = 1'b0;
    d.mem.req  = 1'b0;
    d.mem.we   = 1'b0;
    // Interrupts reach the core only while global enable is on
    d.irq      = i_irq_pend & i_irq_en & {8{q.st[`SRR_GIE_BIT]}};
    case (q.state)
      srr_pkg::SRR_IDLE: begin
        if (taken) begin
          d.req  = i_req;
          d.done = 1'b1;
          case (i_req.op)
            srr_pkg::SRR_OP_LD_REG: begin
              // Register load sets N and Z, which returns later test
              if (i_req.dst < 5'(`SRR_NUM_REGS)) begin
                d.regs[i_req.dst[2:0]]  = i_req.imm;
                d.st[`SRR_N_BIT]        = i_req.imm[31];
                d.st[`SRR_Z_BIT]        = (i_req.imm[31:0] == '0);
                d.st[`SRR_V_BIT]        = 1'b0;
                d.st[`SRR_UF_BIT]       = 1'b0;
                d.wb = '{valid: 1'b1, idx: i_req.dst[2:0], value: i_req.imm};
              end
            end
            srr_pkg::SRR_OP_LD_ST: begin
              d.st = i_req.imm[31:0];
            end
            srr_pkg::SRR_OP_LD_SP: begin
              d.sp = i_req.imm[23:0];
            end
            srr_pkg::SRR_OP_FLOAT_PUSH: begin
              // Pre-increment, then store at the new top; flags untouched
              d.sp        = q.sp + `SRR_ONE24;
              d.mem.req   = 1'b1;
              d.mem.we    = 1'b1;
              d.mem.addr  = q.sp + `SRR_ONE24;
              d.mem.wdata = push_word;
            end
            srr_pkg::SRR_OP_RETI, srr_pkg::SRR_OP_RETS: begin
              // False condition: finish now with nothing changed
              if (cond_ok) begin
                d.done     = 1'b0;
                d.busy     = 1'b1;
                d.state    = srr_pkg::SRR_RD;
                d.mem.req  = 1'b1;
                d.mem.addr = q.sp;
              end
            end
            srr_pkg::SRR_OP_RND: begin
              if (i_req.amode == `SRR_AM_DIR || i_req.amode == `SRR_AM_IND) begin
                d.done     = 1'b0;
                d.busy     = 1'b1;
                d.state    = srr_pkg::SRR_RD;
                d.mem.req  = 1'b1;
                d.mem.addr = (i_req.amode == `SRR_AM_DIR) ? i_req.addr :
                             i_req.addr + (i_req.use_index ? i_req.index :
                             {{16{1'b0}}, i_req.disp});
              end
            end
            default: begin
              d.done = 1'b1;
            end
          endcase
        end
      end
      srr_pkg::SRR_RD: begin
        // Memory sees the read this cycle and answers in the next
        d.state = srr_pkg::SRR_WT;
      end
      srr_pkg::SRR_WT: begin
        d.data = i_mem_rdata;
        if (q.req.op == srr_pkg::SRR_OP_RND) begin
          d.state = srr_pkg::SRR_IDLE;
          d.busy  = 1'b0;
          d.done  = 1'b1;
        end else begin
          d.state = srr_pkg::SRR_FIN;
        end
      end
      srr_pkg::SRR_FIN: begin
        // Pop: load PC from the old top, then post-decrement
        d.pc    = q.data[23:0];
        d.sp    = q.sp - `SRR_ONE24;
        if (q.req.op == srr_pkg::SRR_OP_RETI) begin
          d.st[`SRR_GIE_BIT] = 1'b1;
        end
        d.state = srr_pkg::SRR_IDLE;
        d.busy  = 1'b0;
        d.done  = 1'b1;
      end
      default: begin
        d.state = srr_pkg::SRR_IDLE;
        d.busy  = 1'b0;
      end
    endcase
    // Round commit; outside R0-R7 nothing is written and flags stay
    if (do_rnd && rnd_dst < 5'(`SRR_NUM_REGS)) begin
      d.regs[rnd_dst[2:0]]  = rnd_res[39:0];
      d.st[`SRR_LUF_BIT]    = q.st[`SRR_LUF_BIT] | rnd_res[41];
      d.st[`SRR_LV_BIT]     = q.st[`SRR_LV_BIT] | rnd_res[42];
      d.st[`SRR_UF_BIT]     = rnd_res[41] | rnd_res[40];
      d.st[`SRR_N_BIT]      = rnd_res[31];
      d.st[`SRR_V_BIT]      = rnd_res[42];
      d.wb = '{valid: 1'b1, idx: rnd_dst[2:0], value: rnd_res[39:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////////////////

  // Only constants load under reset
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      q       <= '0;
      q.state <= srr_pkg::SRR_IDLE;
      q.sp    <= `SRR_SP_RST;
      q.pc    <= `SRR_PC_RST;
      q.st    <= `SRR_ST_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state record
  assign o_busy          = q.busy;
  assign o_done          = q.done;
  assign o_mem           = q.mem;
  assign o_wb            = q.wb;
  assign o_pc            = q.pc;
  assign o_stack_pointer = q.sp;
  assign o_status_word   = q.st;
  assign o_irq_take      = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  // A taken return and its four-cycle body
  sequence s_ret_go;
    taken && cond_ok &&
    (i_req.op == srr_pkg::SRR_OP_RETI || i_req.op == srr_pkg::SRR_OP_RETS);
  endsequence
  sequence s_ret_body;
    ##1 o_busy [*3] ##1 (!o_busy && o_done);
  endsequence
  sequence s_push_go;
    taken && i_req.op == srr_pkg::SRR_OP_FLOAT_PUSH;
  endsequence

  a_push_address: assert property (
    s_push_go |=> o_mem.req && o_mem.we && o_mem.addr == $past(o_stack_pointer) + 24'h00_0001
      && o_stack_pointer == o_mem.addr)
    else $error("push address not pre-incremented");

  a_push_word: assert property (
    s_push_go |=> o_mem.wdata == $past(push_word) && o_status_word == $past(o_status_word))
    else $error("push word or flags wrong");

  a_ret_cycles: assert property (s_ret_go |-> s_ret_body)
    else $error("return did not take four cycles");

  a_reti_enable: assert property (
    s_ret_go and (i_req.op == srr_pkg::SRR_OP_RETI) |-> ##4 o_status_word[13])
    else $error("interrupt return left enable clear");

  a_ret_pop: assert property (
    s_ret_go |-> ##4 o_stack_pointer == $past(o_stack_pointer, 4) - 24'h00_0001)
    else $error("return did not decrement stack pointer");

  a_ret_false: assert property (
    taken && !cond_ok && (i_req.op == srr_pkg::SRR_OP_RETS || i_req.op == srr_pkg::SRR_OP_RETI)
    |=> $stable(o_pc) && $stable(o_stack_pointer) && $stable(o_status_word) && !o_busy)
    else $error("false return changed state");

  a_rnd_sign: assert property (
    o_wb.valid && $past(do_rnd) |-> o_status_word[3] == o_wb.value[31])
    else $error("negative flag does not follow result");

  a_rnd_nodst: assert property (
    do_rnd && rnd_dst >= 5'h08 |=> $stable(o_status_word) && !o_wb.valid)
    else $error("round touched flags for a non-extended target");

  a_rnd_latch: assert property (
    do_rnd && q.st[`SRR_LUF_BIT] |=> o_status_word[6])
    else $error("latched underflow was cleared by round");

  a_irq_gate: assert property (
    !o_status_word[13] ##1 !o_status_word[13] |-> o_irq_take == 8'h00)
    else $error("interrupt passed with global enable off");

endmodule

// ==== pkg/srr_defs.svh ====
// Constants for the stack, return and round execution block
`ifndef SRR_DEFS_SVH
`define SRR_DEFS_SVH
// Status word bit positions
`define SRR_C_BIT 0
`define SRR_V_BIT 1
`define SRR_Z_BIT 2
`define SRR_N_BIT 3
`define SRR_UF_BIT 4
`define SRR_LV_BIT 5
`define SRR_LUF_BIT 6
`define SRR_OVM_BIT 7
`define SRR_GIE_BIT 13
// Reset values
`define SRR_SP_RST 24'h00_0100
`define SRR_PC_RST 24'h00_0000
`define SRR_ST_RST 32'h0000_0000
// Extended-precision number layout and rounding
`define SRR_NUM_REGS 8
`define SRR_EXP_ZERO 8'h80
`define SRR_EXP_MAX 8'h7f
`define SRR_EXP_ONE 8'h01
`define SRR_RND_HALF 33'h0_0000_0080
`define SRR_LOW_MASK 32'hffff_ff00
`define SRR_SAT_MANT 32'h7fff_ff00
`define SRR_SIMM_ZERO 4'h8
`define SRR_ONE24 24'h00_0001
// Addressing modes of the round source
`define SRR_AM_REG 2'h0
`define SRR_AM_DIR 2'h1
`define SRR_AM_IND 2'h2
`define SRR_AM_IMM 2'h3
// Condition codes
`define SRR_CC_U 5'h00
`define SRR_CC_LO 5'h01
`define SRR_CC_LS 5'h02
`define SRR_CC_HI 5'h03
`define SRR_CC_HS 5'h04
`define SRR_CC_EQ 5'h05
`define SRR_CC_NE 5'h06
`define SRR_CC_LT 5'h07
`define SRR_CC_LE 5'h08
`define SRR_CC_GT 5'h09
`define SRR_CC_GE 5'h0a
`define SRR_CC_NV 5'h0c
`define SRR_CC_V 5'h0d
`define SRR_CC_NUF 5'h0e
`define SRR_CC_UF 5'h0f
`define SRR_CC_NLV 5'h10
`define SRR_CC_LV 5'h11
`define SRR_CC_NLUF 5'h12
`define SRR_CC_LUF 5'h13
`define SRR_CC_ZUF 5'h14
`endif

// ==== pkg/srr_pkg.sv ====
// Types shared by the stack, return and round execution block
package srr_pkg;
  // Operations accepted on the request port
  typedef enum logic [2:0] {
    SRR_OP_LD_REG, SRR_OP_LD_ST, SRR_OP_LD_SP, SRR_OP_FLOAT_PUSH,
    SRR_OP_RETI, SRR_OP_RETS, SRR_OP_RND
  } srr_op_t;
  // Sequencer states
  typedef enum logic [1:0] {SRR_IDLE, SRR_RD, SRR_WT, SRR_FIN} srr_state_t;
  // One instruction request
  typedef struct packed {
    srr_op_t     op;
    logic [4:0]  cond;
    logic [1:0]  amode;
    logic [2:0]  src;
    logic [4:0]  dst;
    logic [23:0] addr;
    logic [7:0]  disp;
    logic        use_index;
    logic [23:0] index;
    logic [39:0] imm;
  } srr_req_t;
  // Data memory request, answered one cycle later
  typedef struct packed {
    logic        req;
    logic        we;
    logic [23:0] addr;
    logic [31:0] wdata;
  } srr_mem_t;
  // Register write-back report
  typedef struct packed {
    logic        valid;
    logic [2:0]  idx;
    logic [39:0] value;
  } srr_wb_t;
endpackage

// ==== test/srr_mem_model.sv ====
// Behavioural data memory that holds the system stack for the bench
module srr_mem_model (
  input  wire logic          i_clk_sys,
  input  srr_pkg::srr_mem_t  i_mem,
  output logic [31:0]        o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] store [logic [23:0]];  // Sparse word storage
  logic [31:0] word;                  // Word fetched for a read

  initial o_rdata = 32'h0000_0000;

  // Writes land at once; reads answer one cycle later.
  // Outside the answer cycle the bus toggles, so a late sample shows junk.
  always @(posedge i_clk_sys) begin
    if (i_mem.req && i_mem.we) begin
      store[i_mem.addr] = i_mem.wdata;
    end
    if (i_mem.req && !i_mem.we) begin
      word = store.exists(i_mem.addr) ? store[i_mem.addr] : 32'h5a5a_a5a5;
      o_rdata <= word;
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// ==== test/tb_stack_return_round_exec.sv ====
// Self-checking bench for the push, return and round execution unit
`include "srr_defs.svh"

module tb_stack_return_round_exec;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  logic              clk_sys, rstn, req_valid, busy, done;
  srr_pkg::srr_req_t req;
  srr_pkg::srr_mem_t mem;
  srr_pkg::srr_wb_t  wb;
  logic [31:0]       mem_rdata, st;
  logic [7:0]        irq_en, irq_pend, irq_take;
  logic [23:0]       pc, sp;
  logic [23:0]       esp, epc;     // Stack pointer and PC the bench expects
  int                err_count = 0;
  int                check_count = 0;
  int                cycles = 0;
  int                lat;          // Cycles from request to completion pulse

  srr_exec dut (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_req_valid(req_valid), .i_req(req),
    .i_mem_rdata(mem_rdata), .i_irq_en(irq_en), .i_irq_pend(irq_pend), .o_busy(busy),
    .o_done(done), .o_mem(mem), .o_wb(wb), .o_pc(pc), .o_stack_pointer(sp),
    .o_status_word(st), .o_irq_take(irq_take));
  srr_mem_model stack_mem (.i_clk_sys(clk_sys), .i_mem(mem), .o_rdata(mem_rdata));

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hang ends the run as a failure
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  // Builds a request; unused fields stay zero
  function automatic srr_pkg::srr_req_t rq(srr_pkg::srr_op_t op, logic [39:0] imm = '0,
      logic [2:0] src = 3'h0, logic [4:0] dst = 5'h0, logic [4:0] cond = 5'h0,
      logic [1:0] am = 2'h0, logic [23:0] addr = '0, logic [7:0] disp = '0,
      logic ix = 1'b0, logic [23:0] index = '0);
    return '{op, cond, am, src, dst, addr, disp, ix, index, imm};
  endfunction

  // Presents a request for one edge from a falling edge, then counts to done
  task automatic go(input srr_pkg::srr_req_t r);
    req = r;
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    lat = 1;
    while (done !== 1'b1 && lat < 16) begin
      @(negedge clk_sys);
      lat++;
    end
  endtask

  task automatic ld_reg(input logic [4:0] i, input logic [39:0] v);
    go(rq(srr_pkg::SRR_OP_LD_REG, v, 3'h0, i));
  endtask

  task automatic ld_st(input logic [31:0] v);
    go(rq(srr_pkg::SRR_OP_LD_ST, {8'h00, v}));
  endtask

  // Puts a return address on the stack through R1
  task automatic pushv(input logic [23:0] v);
    ld_reg(5'h1, {8'h00, v, 8'h00});
    go(rq(srr_pkg::SRR_OP_FLOAT_PUSH, '0, 3'h1));
    esp++;
  endtask

  // Truth of each condition code for the given flags; unknown codes are false
  function automatic bit ctrue(logic [4:0] c, logic [31:0] s);
    logic cf, v, z, n, u, lv, lu;
    {lu, lv, u, n, z, v, cf} = s[6:0];
    case (c)
      `SRR_CC_U:    return 1'b1;
      `SRR_CC_LO:   return cf;
      `SRR_CC_LS:   return cf | z;
      `SRR_CC_HI:   return !cf && !z;
      `SRR_CC_HS:   return !cf;
      `SRR_CC_EQ:   return z;
      `SRR_CC_NE:   return !z;
      `SRR_CC_LT:   return n;
      `SRR_CC_LE:   return n | z;
      `SRR_CC_GT:   return !n && !z;
      `SRR_CC_GE:   return !n;
      `SRR_CC_NV:   return !v;
      `SRR_CC_V:    return v;
      `SRR_CC_NUF:  return !u;
      `SRR_CC_UF:   return u;
      `SRR_CC_NLV:  return !lv;
      `SRR_CC_LV:   return lv;
      `SRR_CC_NLUF: return !lu;
      `SRR_CC_LUF:  return lu;
      `SRR_CC_ZUF:  return z | u;
      default:      return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Float push with every flag and saturate mode set
  task automatic t_push();
    ld_reg(5'h2, 40'h02_5c12_8081);
    ld_st(32'h0000_00ff);
    go(rq(srr_pkg::SRR_OP_FLOAT_PUSH, '0, 3'h2));
    esp++;
    check("push latency", lat, 1);
    check("push write", {mem.req, mem.we}, 2'b11);
    check("push addr", mem.addr, esp);
    check("push data", mem.wdata, 32'h025c_1280);
    check("push pointer", sp, esp);
    check("push flags", st, 32'h0000_00ff);
    $display("test push done");
  endtask

  // Taken returns, then interrupt gating by the global enable
  task automatic t_ret();
    pushv(24'h000456);
    ld_st(32'h0000_0000);
    go(rq(srr_pkg::SRR_OP_RETS, '0, 3'h0, 5'h0, `SRR_CC_U));
    esp--;
    check("rets latency", lat, 4);
    check("rets pc", pc, 24'h000456);
    check("rets pointer", sp, esp);
    check("rets flags", st, 32'h0000_0000);
    irq_en = 8'h0f;
    irq_pend = 8'h33;
    pushv(24'h000123);
    check("irq masked", irq_take, 8'h00);
    go(rq(srr_pkg::SRR_OP_RETI, '0, 3'h0, 5'h0, `SRR_CC_U));
    esp--;
    epc = 24'h000123;
    check("reti latency", lat, 4);
    check("reti pc", pc, epc);
    check("reti pointer", sp, esp);
    check("reti status", st, 32'h0000_2000);
    @(negedge clk_sys);
    check("irq enabled", irq_take, 8'h03);
    irq_en = 8'hff;
    repeat (2) @(negedge clk_sys);
    check("irq all", irq_take, 8'h33);
    $display("test returns done");
  endtask

  // Every condition code, taken or not, for one flag pattern
  task automatic t_conds(input logic [31:0] flags);
    bit t;
    for (int c = 0; c < 22; c++) begin
      pushv(24'h001000 + 24'(c));
      ld_st(flags);
      t = ctrue(5'(c), flags);
      go(rq(srr_pkg::SRR_OP_RETS, '0, 3'h0, 5'h0, 5'(c)));
      if (t) begin
        epc = 24'h001000 + 24'(c);
        esp--;
      end
      check("cond latency", lat, t ? 4 : 1);
      check("cond pc", pc, epc);
      check("cond pointer", sp, esp);
      check("cond flags", st, flags);
    end
    // Negative flag left by a register load decides the return
    pushv(24'h002000);
    ld_reg(5'h2, 40'h00_8000_0000);
    go(rq(srr_pkg::SRR_OP_RETS, '0, 3'h0, 5'h0, `SRR_CC_LT));
    esp--;
    check("flag source", pc, 24'h002000);
    epc = 24'h002000;
    $display("test conditions done");
  endtask

  // Rounding cases, operand modes and a destination outside R0-R7
  task automatic chk_rnd(input srr_pkg::srr_req_t r, input int l, input logic [39:0] v);
    go(r);
    check("mode latency", lat, l);
    check("mode write", {wb.valid, wb.idx}, 4'hc);
    check("mode value", wb.value, v);
  endtask

  task automatic t_round();
    logic [39:0] sv [8] = '{40'h07_33c1_6eef, 40'h01_0000_0080, 40'h01_8000_0080,
      40'h7f_7fff_ff80, 40'h7f_7fff_ff80, 40'h80_0000_0000, 40'h80_0000_1200,
      40'h05_7fff_ff80};
    logic [39:0] rv [8] = '{40'h07_33c1_6f00, 40'h01_0000_0100, 40'h01_8000_0100,
      40'h80_0000_0000, 40'h7f_7fff_ff00, 40'h80_0000_0000, 40'h80_0000_0000,
      40'h06_0000_0000};
    logic [7:0] s0 [8] = '{8'h05, 8'h62, 8'h10, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    logic [7:0] s1 [8] = '{8'h05, 8'h60, 8'h08, 8'h22, 8'ha2, 8'h10, 8'h50, 8'h00};
    for (int i = 0; i < 8; i++) begin
      ld_reg(5'h5, sv[i]);
      ld_st({24'h0, s0[i]});
      go(rq(srr_pkg::SRR_OP_RND, '0, 3'h5, 5'h2));
      check("round latency", lat, 1);
      check("round write", {wb.valid, wb.idx}, 4'ha);
      check("round value", wb.value, rv[i]);
      check("round flags", st, {24'h0, s1[i]});
    end
    ld_reg(5'h3, 40'h02_5c12_8081);
    go(rq(srr_pkg::SRR_OP_FLOAT_PUSH, '0, 3'h3));
    esp++;
    chk_rnd(rq(srr_pkg::SRR_OP_RND, '0, 3'h0, 5'h4, 5'h0, `SRR_AM_DIR, esp), 3,
      40'h02_5c12_8000);
    chk_rnd(rq(srr_pkg::SRR_OP_RND, '0, 3'h0, 5'h4, 5'h0, `SRR_AM_IND, esp - 24'h5,
      8'h5), 3, 40'h02_5c12_8000);
    chk_rnd(rq(srr_pkg::SRR_OP_RND, '0, 3'h0, 5'h4, 5'h0, `SRR_AM_IND, esp - 24'h9,
      8'h0, 1'b1, 24'h9), 3, 40'h02_5c12_8000);
    chk_rnd(rq(srr_pkg::SRR_OP_RND, '0, 3'h0, 5'h4, 5'h0, `SRR_AM_IMM), 1, 40'h0);
    ld_st(32'h0000_001a);
    go(rq(srr_pkg::SRR_OP_RND, '0, 3'h5, 5'h8));
    check("far dst write", wb.valid, 1'b0);
    check("far dst flags", st, 32'h0000_001a);
    // A loaded stack pointer is the base for the next pre-increment
    go(rq(srr_pkg::SRR_OP_LD_SP, 40'h00_0000_0800));
    esp = 24'h000800;
    check("loaded pointer", sp, esp);
    go(rq(srr_pkg::SRR_OP_FLOAT_PUSH, '0, 3'h3));
    esp++;
    check("push after load", mem.addr, esp);
    $display("test round done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, then each scenario in turn
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    irq_en = 8'h00;
    irq_pend = 8'h00;
    esp = `SRR_SP_RST;
    epc = `SRR_PC_RST;
    repeat (3) @(negedge clk_sys);
    check("reset pc", pc, 24'h000000);
    check("reset pointer", sp, 24'h000100);
    check("reset status", st, 32'h0000_0000);
    check("reset strobes", {busy, done, mem.req, wb.valid, irq_take}, 12'h000);
    rstn = 1'b1;
    t_push();
    t_ret();
    t_conds(32'h0000_0055);
    t_conds(32'h0000_00aa);
    t_round();
    complete_run();
  end
endmodule
